// ---- verilog/timer_waveform_output_control.sv ----
// 8-bit timer with two compare channels and waveform outputs
// assumes a register master on ref_clk; pin direction is set elsewhere
//
// What this block does
// - nonzero output-mode field hands the channel's pin to the waveform output
// - channel A non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match
// - channel A fast PWM: 2 clear/set-at-bottom, 3 inverse, 1 toggles if high mode
// - channel A fast PWM, compare equals top: ignore match, act at bottom
// - channel A phase PWM: 2 clear up/set down, 3 reverse, 1 toggles if high
// - channel A phase PWM, compare equals top: ignore match, act at top
// - channel B non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match
// - channel B fast PWM: 1 reserved, 2 non-inverting, 3 inverting
// - channel B fast PWM, compare equals top: ignore match, act at wrap
// - channel B phase PWM: 1 reserved, 2 clear up/set down, 3 reverse
// - channel B phase PWM, compare equals top: ignore match, act at top
// - mode is high bit of second register over two low bits of first
// - normal tops at max, clear-on-match at compare A; immediate update
// - fast PWM tops at max or compare A; update at bottom
// - phase PWM tops at max or compare A; update at top, flag at bottom
// - force strobe in non-PWM applies match action, no flag, reads zero
// - clock select stops at 0, else divides by 1 to 1024
// - each compare value is compared continuously with the counter
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_waveform_consts.svh"

module timer_waveform_output_control #(
   parameter int PRESCALE_W = `TW_PS_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // channel A waveform pin
   output logic chan_a_wave_pin,
   output logic chan_a_wave_en,
   // channel B waveform pin
   output logic chan_b_wave_pin,
   output logic chan_b_wave_en
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // map a three-bit mode onto its waveform class
   function automatic timer_waveform_pkg::wave_class_t class_of(
      input logic [2:0] m
   );
      timer_waveform_pkg::wave_class_t c;
      c = timer_waveform_pkg::wave_plain;
      if (m == `TW_MODE_FAST_FF || m == `TW_MODE_FAST_A) begin
         c = timer_waveform_pkg::wave_fast;
      end else if (m == `TW_MODE_PHASE_FF || m == `TW_MODE_PHASE_A) begin
         c = timer_waveform_pkg::wave_phase;
      end
      return c;
   endfunction : class_of

   // next level of one waveform output; shared by both channels
   function automatic logic wave_next(
      input logic cur,
      input logic [1:0] com,
      input timer_waveform_pkg::wave_class_t cls,
      input logic is_a,
      input logic hi,
      input logic match,
      input logic force_hit,
      input logic top_eq,
      input timer_waveform_pkg::count_dir_t dir,
      input logic wrap_evt,
      input logic top_evt
   );
      logic nxt;
      nxt = cur;
      unique case (cls)
         timer_waveform_pkg::wave_plain: begin
            if (match || force_hit) begin
               unique case (com)
                  2'h0: nxt = cur;
                  2'h1: nxt = ~cur;
                  2'h2: nxt = 1'b0;
                  2'h3: nxt = 1'b1;
               endcase
            end
         end
         timer_waveform_pkg::wave_fast: begin
            if (com == 2'h1) begin
               // channel B treats this code as reserved
               if (is_a && hi && match) begin
                  nxt = ~cur;
               end
            end else if (com[1]) begin
               if (wrap_evt) begin
                  nxt = ~com[0];
               end else if (match && !top_eq) begin
                  nxt = com[0];
               end
            end
         end
         timer_waveform_pkg::wave_phase: begin
            if (com == 2'h1) begin
               if (is_a && hi && match) begin
                  nxt = ~cur;
               end
            end else if (com[1]) begin
               if (top_eq) begin
                  if (top_evt) begin
                     nxt = ~com[0];
                  end
               end else if (match) begin
                  if (dir == timer_waveform_pkg::count_up) begin
                     nxt = com[0];
                  end else begin
                     nxt = ~com[0];
                  end
               end
            end
         end
         default: nxt = cur;
      endcase
      return nxt;
   endfunction : wave_next

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   timer_waveform_pkg::byte_t out_mode_q;
   timer_waveform_pkg::byte_t force_clk_q;
   timer_waveform_pkg::byte_t cnt_q;
   timer_waveform_pkg::byte_t cmp_a_q;
   timer_waveform_pkg::byte_t cmp_b_q;
   timer_waveform_pkg::byte_t act_a_q;
   timer_waveform_pkg::byte_t act_b_q;
   timer_waveform_pkg::count_dir_t dir_q;
   logic [2:0] status_q;
   logic block_q;
   logic wave_a_q;
   logic wave_b_q;
   timer_waveform_pkg::byte_t rdata_q;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [2:0] waveform_mode_field;
   logic [1:0] chan_a_output_mode;
   logic [1:0] chan_b_output_mode;
   logic [2:0] clock_select_field;
   timer_waveform_pkg::wave_class_t cls;
   timer_waveform_pkg::byte_t top;
   logic top_from_a;
   logic tick;
   logic wr_out_mode;
   logic wr_force_clk;
   logic wr_count;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic wrap_evt;
   logic top_evt;
   logic ovf_evt;
   logic update;

   // mode assembled across the two control registers
   assign waveform_mode_field = {force_clk_q[`TW_WGM_HI],
                                 out_mode_q[`TW_WGM_MID:`TW_WGM_LO]};
   assign chan_a_output_mode = out_mode_q[`TW_COM_A_HI:`TW_COM_A_LO];
   assign chan_b_output_mode = out_mode_q[`TW_COM_B_HI:`TW_COM_B_LO];
   assign clock_select_field = force_clk_q[`TW_CS_HI:`TW_CS_LO];
   assign cls = class_of(waveform_mode_field);

   // top is max unless the mode takes it from compare A
   assign top_from_a = (waveform_mode_field == `TW_MODE_CTC) ||
                       (waveform_mode_field == `TW_MODE_PHASE_A) ||
                       (waveform_mode_field == `TW_MODE_FAST_A);
   assign top = top_from_a ? act_a_q : `TW_MAX;

   // register write strobes
   assign wr_out_mode = reg_wr && (reg_addr == `TW_OFS_OUT_MODE);
   assign wr_force_clk = reg_wr && (reg_addr == `TW_OFS_FORCE_CLK);
   assign wr_count = reg_wr && (reg_addr == `TW_OFS_COUNT);

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   timer_prescaler #(
      .DIV_W(PRESCALE_W)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clock_select_field(clock_select_field),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------

   // continuous compare, taken on the tick that sees equality
   assign match_a = tick && !block_q && (cnt_q == act_a_q);
   assign match_b = tick && !block_q && (cnt_q == act_b_q);

   // forced match only outside PWM modes
   assign force_a = wr_force_clk && reg_wdata[`TW_FORCE_A] &&
                    (cls == timer_waveform_pkg::wave_plain);
   assign force_b = wr_force_clk && reg_wdata[`TW_FORCE_B] &&
                    (cls == timer_waveform_pkg::wave_plain);

   // fast PWM wraps from top to bottom; phase PWM turns at top
   assign wrap_evt = tick && (cls == timer_waveform_pkg::wave_fast) &&
                     (cnt_q == top);
   assign top_evt = tick && (cls == timer_waveform_pkg::wave_phase) &&
                    (dir_q == timer_waveform_pkg::count_up) &&
                    (cnt_q == top);

   // overflow point by mode
   always_comb begin
      ovf_evt = 1'b0;
      if (tick) begin
         if (cls == timer_waveform_pkg::wave_phase) begin
            ovf_evt = (dir_q == timer_waveform_pkg::count_down) &&
                      (cnt_q == `TW_BOTTOM);
         end else if (waveform_mode_field == `TW_MODE_FAST_A) begin
            ovf_evt = (cnt_q == top);
         end else begin
            ovf_evt = (cnt_q == `TW_MAX);
         end
      end
   end

   // compare update point by class
   always_comb begin
      unique case (cls)
         timer_waveform_pkg::wave_fast: update = wrap_evt;
         timer_waveform_pkg::wave_phase: update = top_evt;
         default: update = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------

   // output mode and low mode bits; bits 3:2 are not stored
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         out_mode_q <= `TW_RESET_BYTE;
      end else if (wr_out_mode) begin
         out_mode_q <= reg_wdata & 8'hf3;
      end
   end

   // high mode bit and clock select; force bits are strobes, not kept
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         force_clk_q <= `TW_RESET_BYTE;
      end else if (wr_force_clk) begin
         force_clk_q <= reg_wdata & 8'h0f;
      end
   end

   // ----------------------------------------------------------------
   // compare values
   // ----------------------------------------------------------------

   // software side of each compare value
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_a_q <= `TW_RESET_BYTE;
         cmp_b_q <= `TW_RESET_BYTE;
      end else begin
         if (reg_wr && (reg_addr == `TW_OFS_CMP_A)) begin
            cmp_a_q <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `TW_OFS_CMP_B)) begin
            cmp_b_q <= reg_wdata;
         end
      end
   end

   // active comparator values; in PWM modes this stops glitched
   // pulses when software changes duty mid-period
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         act_a_q <= `TW_RESET_BYTE;
         act_b_q <= `TW_RESET_BYTE;
      end else if (update) begin
         act_a_q <= cmp_a_q;
         act_b_q <= cmp_b_q;
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------

   // counting sequence per class
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= `TW_BOTTOM;
         dir_q <= timer_waveform_pkg::count_up;
      end else if (wr_count) begin
         cnt_q <= reg_wdata;
      end else if (tick) begin
         if (cls == timer_waveform_pkg::wave_phase) begin
            if (top == `TW_BOTTOM) begin
               cnt_q <= `TW_BOTTOM;
            end else if (dir_q == timer_waveform_pkg::count_up) begin
               if (cnt_q >= top) begin
                  dir_q <= timer_waveform_pkg::count_down;
                  cnt_q <= cnt_q - 8'h01;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end else if (cnt_q == `TW_BOTTOM) begin
               dir_q <= timer_waveform_pkg::count_up;
               cnt_q <= cnt_q + 8'h01;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end else begin
            dir_q <= timer_waveform_pkg::count_up;
            if (cnt_q == top) begin
               cnt_q <= `TW_BOTTOM;
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end

   // a counter write hides the match on the next tick
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         block_q <= 1'b0;
      end else if (wr_count) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------

   // write one to clear; an event in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= 3'h0;
      end else begin
         status_q <= (status_q & ~((reg_wr &&
                      (reg_addr == `TW_OFS_STATUS)) ? reg_wdata[2:0] :
                      3'h0)) |
                     {match_b, match_a, ovf_evt};
      end
   end

   // ----------------------------------------------------------------
   // waveform outputs
   // ----------------------------------------------------------------

   // one level per channel, driven from the shared rule function
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         wave_a_q <= wave_next(wave_a_q, chan_a_output_mode, cls, 1'b1,
                               force_clk_q[`TW_WGM_HI], match_a, force_a,
                               act_a_q == top, dir_q, wrap_evt,
                               top_evt);
         wave_b_q <= wave_next(wave_b_q, chan_b_output_mode, cls, 1'b0,
                               force_clk_q[`TW_WGM_HI], match_b, force_b,
                               act_b_q == top, dir_q, wrap_evt,
                               top_evt);
      end
   end

   // pin takeover; the driver itself still needs direction set
   assign chan_a_wave_pin = wave_a_q;
   assign chan_b_wave_pin = wave_b_q;
   assign chan_a_wave_en = |chan_a_output_mode;
   assign chan_b_wave_en = |chan_b_output_mode;

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= `TW_RESET_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `TW_OFS_OUT_MODE: rdata_q <= out_mode_q;
            `TW_OFS_FORCE_CLK: rdata_q <= force_clk_q;
            `TW_OFS_COUNT: rdata_q <= cnt_q;
            `TW_OFS_CMP_A: rdata_q <= cmp_a_q;
            `TW_OFS_CMP_B: rdata_q <= cmp_b_q;
            `TW_OFS_STATUS: rdata_q <= {5'h00, status_q};
            default: rdata_q <= `TW_RESET_BYTE;
         endcase
      end else begin
         rdata_q <= `TW_RESET_BYTE;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : timer_waveform_output_control
`default_nettype wire

// ---- verilog/timer_waveform_consts.svh ----
// offsets, field positions, reset values and counts of the timer waveform
// block; assumes an 8-bit register port and an 8-bit counter
`ifndef TIMER_WAVEFORM_CONSTS_SVH
`define TIMER_WAVEFORM_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TW_OFS_OUT_MODE 8'hb0
`define TW_OFS_FORCE_CLK 8'hb1
`define TW_OFS_COUNT 8'hb2
`define TW_OFS_CMP_A 8'hb3
`define TW_OFS_CMP_B 8'hb4
`define TW_OFS_STATUS 8'hb5
`define TW_RESET_BYTE 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TW_COM_A_HI 7
`define TW_COM_A_LO 6
`define TW_COM_B_HI 5
`define TW_COM_B_LO 4
`define TW_WGM_MID 1
`define TW_WGM_LO 0
`define TW_FORCE_A 7
`define TW_FORCE_B 6
`define TW_WGM_HI 3
`define TW_CS_HI 2
`define TW_CS_LO 0
`define TW_ST_OVF 0
`define TW_ST_MATCH_A 1
`define TW_ST_MATCH_B 2

// ----------------------------------------------------------------
// waveform modes and counter limits
// ----------------------------------------------------------------
`define TW_MODE_NORMAL 3'h0
`define TW_MODE_PHASE_FF 3'h1
`define TW_MODE_CTC 3'h2
`define TW_MODE_FAST_FF 3'h3
`define TW_MODE_PHASE_A 3'h5
`define TW_MODE_FAST_A 3'h7
`define TW_MAX 8'hff
`define TW_BOTTOM 8'h00

// ----------------------------------------------------------------
// prescaler tap masks (divide by mask + 1)
// ----------------------------------------------------------------
`define TW_PS_W 10
`define TW_PS_MASK_8 10'h007
`define TW_PS_MASK_32 10'h01f
`define TW_PS_MASK_64 10'h03f
`define TW_PS_MASK_128 10'h07f
`define TW_PS_MASK_256 10'h0ff
`define TW_PS_MASK_1024 10'h3ff

`endif

// ---- verilog/timer_waveform_pkg.sv ----
// types shared by the timer waveform block
// assumes nothing of its surroundings
`default_nettype none

package timer_waveform_pkg;

   typedef logic [7:0] byte_t;

   // how the selected mode shapes the waveform
   typedef enum logic [1:0] {wave_plain, wave_fast, wave_phase} wave_class_t;

   // counting direction, only ever down in phase-correct modes
   typedef enum logic {count_up, count_down} count_dir_t;

endpackage : timer_waveform_pkg
`default_nettype wire

// ---- verilog/timer_prescaler.sv ----
// clock prescaler: one-cycle timer ticks from the reference clock
// assumes the select field comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "timer_waveform_consts.svh"

module timer_prescaler #(
   parameter int DIV_W = `TW_PS_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // selection and tick
   input wire logic [2:0] clock_select_field,
   output logic tick
);

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] mask;

   // free-running divider; all taps share it so a change of select
   // may give one short first period, which is accepted
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // tap selection, select 0 stops the timer
   always_comb begin
      mask = '0;
      tick = 1'b0;
      unique case (clock_select_field)
         3'h0: tick = 1'b0;
         3'h1: tick = 1'b1;
         3'h2: mask = DIV_W'(`TW_PS_MASK_8);
         3'h3: mask = DIV_W'(`TW_PS_MASK_32);
         3'h4: mask = DIV_W'(`TW_PS_MASK_64);
         3'h5: mask = DIV_W'(`TW_PS_MASK_128);
         3'h6: mask = DIV_W'(`TW_PS_MASK_256);
         3'h7: mask = DIV_W'(`TW_PS_MASK_1024);
      endcase
      if (clock_select_field > 3'h1) begin
         tick = ((div_q & mask) == mask);
      end
   end

endmodule : timer_prescaler
`default_nettype wire

// ---- bench/timer_waveform_props.sv ----
// checker: port assertions for the timer waveform block
// assumes it is bound onto timer_waveform_output_control
`timescale 1ns/1ps
`default_nettype none

module timer_waveform_props #(
   parameter int PRESCALE_W = 10
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // waveform pins
   input wire logic chan_a_wave_pin,
   input wire logic chan_a_wave_en,
   input wire logic chan_b_wave_pin,
   input wire logic chan_b_wave_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] oc_q;
   logic wr_oc;
   logic wr_fc;
   assign wr_oc = reg_wr && reg_addr == 8'hb0;
   assign wr_fc = reg_wr && reg_addr == 8'hb1;
   // copy of the mode register: force acts only in non-PWM modes
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) oc_q <= 8'h00;
      else if (wr_oc) oc_q <= reg_wdata;
   end
   rd_idle_a: assert property ((!reg_rd || reg_addr < 8'hb0 ||
      reg_addr > 8'hb5) |=> reg_rdata == 8'h00)
      else $error("read data not zero");
   en_a_follow_a: assert property (
      wr_oc |=> chan_a_wave_en == (oc_q[7:6] != 2'h0))
      else $error("channel a enable wrong");
   en_b_follow_a: assert property (
      wr_oc |=> chan_b_wave_en == (oc_q[5:4] != 2'h0))
      else $error("channel b enable wrong");
   en_hold_a: assert property (
      !wr_oc |=> $stable(chan_a_wave_en) && $stable(chan_b_wave_en))
      else $error("enable moved without write");
   mode_gap_a: assert property (
      reg_rd && reg_addr == 8'hb0 |=> reg_rdata[3:2] == 2'h0)
      else $error("mode register gap bits set");
   force_zero_a: assert property (
      reg_rd && reg_addr == 8'hb1 |=> reg_rdata[7:4] == 4'h0)
      else $error("force bits read back");
   force_a_act_a: assert property (
      wr_fc && reg_wdata[7] && !oc_q[0] && oc_q[7] ##1 !wr_oc
      |=> chan_a_wave_pin == oc_q[6])
      else $error("force a did not act");
   force_b_act_a: assert property (
      wr_fc && reg_wdata[6] && !oc_q[0] && oc_q[5] ##1 !wr_oc
      |=> chan_b_wave_pin == oc_q[4])
      else $error("force b did not act");
endmodule : timer_waveform_props

bind timer_waveform_output_control timer_waveform_props #(
   .PRESCALE_W(PRESCALE_W)
) props_i (
   .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .chan_a_wave_pin(chan_a_wave_pin),
   .chan_a_wave_en(chan_a_wave_en), .chan_b_wave_pin(chan_b_wave_pin),
   .chan_b_wave_en(chan_b_wave_en)
);
`default_nettype wire

// ---- bench/timer_waveform_output_control_test.sv ----
// testbench: register-port tests of the timer waveform block
// assumes design files and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module timer_waveform_output_control_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic pa, ea, pb, eb;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [15:0] ha, hb;
   logic [7:0] v, c0;
   int divs [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

   timer_waveform_output_control DUT (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chan_a_wave_pin(pa), .chan_a_wave_en(ea),
      .chan_b_wave_pin(pb), .chan_b_wave_en(eb)
   );

   // 10 MHz clock; the watchdog stops a hung run well past the tests
   initial forever #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   // the trailing 1 ns keeps two strobes from landing in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // high cycles of both pins over n cycles; phase does not matter;
   // sampled mid-cycle so no read races the launching edge
   task automatic duty(input int n);
      ha = 16'h0000;
      hb = 16'h0000;
      repeat (n) begin
         @(negedge ref_clk);
         ha = ha + 16'(pa);
         hb = hb + 16'(pb);
      end
   endtask : duty
   task automatic tally_and_finish;
      if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int a = 8'hae; a <= 8'hb6; a++) begin
         rd(8'(a), v);
         check("reset", 16'(v), 16'h0000);
      end
      // read-back, and force ignored in a PWM mode (3; the same write then makes it 7)
      wr(8'hb0, 8'hff);
      rd(8'hb0, v);
      check("outmode", 16'(v), 16'h00f3);
      wr(8'hb1, 8'hc8);
      rd(8'hb1, v);
      check("forceclk", 16'(v), 16'h0008);
      check("pwm_force", 16'({pa, pb}), 16'h0000);
      // force in mode 0, timer stopped: a set, b toggle, then clear
      wr(8'hb1, 8'h00);
      wr(8'hb0, 8'hd0);
      wr(8'hb1, 8'hc0);
      @(posedge ref_clk);
      #1 check("force_set", 16'({pa, pb}), 16'h0003);
      check("enable", 16'({ea, eb}), 16'h0003);
      wr(8'hb0, 8'ha0);
      wr(8'hb1, 8'hc0);
      @(posedge ref_clk);
      #1 check("force_clr", 16'({pa, pb}), 16'h0000);
      rd(8'hb5, v);
      check("force_flag", 16'(v), 16'h0000);
      wr(8'hb0, 8'h00);
      check("disable", 16'({ea, eb}), 16'h0000);
      // normal mode: a set at 5, b toggle at 7, period 256
      wr(8'hb3, 8'h05);
      wr(8'hb4, 8'h07);
      wr(8'hb0, 8'hd0);
      wr(8'hb1, 8'h01);
      // let the first match at 5 land before counting high cycles
      repeat (8) @(posedge ref_clk);
      duty(512);
      check("norm_a", ha, 16'd512);
      check("norm_b", hb, 16'd256);
      rd(8'hb5, v);
      check("status", 16'(v), 16'h0007);
      wr(8'hb0, 8'hb0);
      repeat (256) @(posedge ref_clk);
      duty(256);
      check("clr_a", ha, 16'd0);
      check("set_b", hb, 16'd256);
      // clear-on-match: period 0x20, both toggle once a period
      wr(8'hb3, 8'h1f);
      wr(8'hb0, 8'h52);
      repeat (300) @(posedge ref_clk);
      duty(64);
      check("ctc", ha + hb, 16'd64);
      // fast PWM, top 0xff: a non-inverting, b inverting
      wr(8'hb3, 8'h40);
      wr(8'hb4, 8'h80);
      wr(8'hb0, 8'hb3);
      repeat (520) @(posedge ref_clk);
      duty(256);
      check("fast_a", ha, 16'h0041);
      check("fast_b", hb, 16'h007f);
      // fast PWM, top from compare a
      wr(8'hb3, 8'h3f);
      wr(8'hb4, 8'h10);
      wr(8'hb1, 8'h09);
      repeat (600) @(posedge ref_clk);
      duty(64);
      check("fast7_a", ha, 16'h0040);
      check("fast7_b", hb, 16'h002f);
      wr(8'hb4, 8'h3f);
      repeat (130) @(posedge ref_clk);
      duty(64);
      check("fast7_bt", hb, 16'h0000);
      // phase-correct, top 0xff, period 510
      wr(8'hb1, 8'h01);
      wr(8'hb0, 8'hb1);
      wr(8'hb3, 8'h80);
      wr(8'hb4, 8'h40);
      repeat (1100) @(posedge ref_clk);
      duty(510);
      check("phase_a", ha, 16'h0100);
      check("phase_b", hb, 16'h017e);
      // phase-correct, top from compare a, both compares at top
      wr(8'hb3, 8'h3f);
      wr(8'hb4, 8'h3f);
      wr(8'hb1, 8'h09);
      repeat (1100) @(posedge ref_clk);
      duty(126);
      check("phase5_a", ha, 16'd126);
      check("phase5_b", hb, 16'd0);
      // clock select: counter steps over 4 periods of each divider
      wr(8'hb0, 8'h00);
      for (int s = 0; s < 8; s++) begin
         wr(8'hb1, 8'(s));
         rd(8'hb2, c0);
         repeat (4 * divs[s] - 2) @(posedge ref_clk);
         rd(8'hb2, v);
         check("steps", 16'(8'(v - c0)), (s == 0) ? 16'h0 : 16'h4);
      end
      tally_and_finish();
   end
endmodule : timer_waveform_output_control_test
`default_nettype wire
